// ===== pkg/gcd_params.svh
// Register offsets, command codes, reset values and timing for the command dispatcher
// Assumes inclusion by its bare name from the package and the design
`ifndef GCD_PARAMS_SVH
`define GCD_PARAMS_SVH
// Byte addresses on the register bus
`define GCD_ADDR_CMD 8'h00
`define GCD_ADDR_WDL 8'h04
`define GCD_ADDR_WDH 8'h08
`define GCD_ADDR_RDL 8'h0c
`define GCD_ADDR_RDH 8'h10
`define GCD_ADDR_OUT 8'h14
`define GCD_ADDR_PORT 8'h18
`define GCD_ADDR_STAT 8'h1c
// Command code groups
`define GCD_CMD_WR_FIRST 8'hc0
`define GCD_CMD_WR_LAST 8'hc8
`define GCD_CMD_RD_FIRST 8'hd0
`define GCD_CMD_RD_LAST 8'hd8
`define GCD_CMD_RD_VIEW 8'hd9
`define GCD_CMD_RD_TIMER 8'hda
`define GCD_CMD_TMR_SINGLE 8'he0
`define GCD_CMD_TMR_CONT 8'he1
`define GCD_CMD_TMR_STOP 8'he2
`define GCD_CMD_TMR_CSTOP 8'he3
`define GCD_CMD_TRANS_CLR 8'he4
`define GCD_CMD_VIEW_FIRST 8'he5
`define GCD_CMD_VIEW_LAST 8'he9
`define GCD_CMD_LATCH 8'hea
`define GCD_CMD_OUTSET 8'heb
`define GCD_RD_OFFSET 8'h10
// Reset values
`define GCD_RST_DIRPOL 16'h0000
`define GCD_RST_VIEW 8'he6
// Busy time after a command, in device clocks
`define GCD_BUSY_CYCLES 2
`endif

// ===== pkg/gcd_pkg.sv
// Types for the command dispatcher
// Assumes the params header is on the include path
package gcd_pkg;
`include "gcd_params.svh"
    typedef enum logic [1:0] {GCD_IDLE, GCD_BUSY} gcd_state_t;
    typedef enum logic [1:0] {GCD_TMR_OFF, GCD_TMR_ONE, GCD_TMR_RUN, GCD_TMR_END} gcd_tmr_t;
    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } gcd_axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } gcd_axi_rsp_t;
    typedef struct packed {
        gcd_state_t state;
        logic [1:0] busy_cnt;
        logic [7:0] cmd;
        logic [7:0] wdl;
        logic [7:0] wdh;
        logic [7:0] rdl;
        logic [7:0] rdh;
        logic [8:0][15:0] setting;
        logic [7:0] view;
        logic [31:0] out_val;
        logic [31:0] out_live;
        logic [31:0] latch;
        logic [31:0] trans;
        logic [31:0] in_prev;
        gcd_tmr_t tmr;
        logic [15:0] tmr_cnt;
        logic [31:0] in_s1;
        logic [31:0] in_s2;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        gcd_axi_rsp_t rsp;
        logic [31:0] pin_out;
        logic [31:0] pin_oe_n;
    } gcd_state_s_t;
endpackage

// ===== rtl/gcd_top.sv
// Command dispatcher of a 32-bit GPIO device, with an AXI4-Lite register slave
// Assumes one 100 MHz clock mclk, synchronous active-high rst, pins from outside the clock
//
// Summary of operation
// RL1 - Host loads low then high data byte before writing the command code.
// RL2 - One-byte writes use only the low byte; high byte need not be zero.
// RL3 - Readback code puts low result byte in low, high byte in high register.
// RL4 - One-byte readback puts byte in low register, high register forced zero.
// RL5 - Action commands take no data and run as soon as written.
// RL6 - Codes C0 to C8 are two-byte configuration writes.
// RL7 - Codes D0 to D8 read back the setting of the code 10h lower.
// RL8 - Code D9 reads back the selected port read view as one byte.
// RL9 - Code DA reads back the running timer count as two bytes.
// RL10 - E0 single run, E1 continuous, E2 stop, E3 stop at cycle end.
// RL11 - E4 clears all stored input transition information.
// RL12 - E5 to E9 select the port read view.
// RL13 - EA latches all inputs at once, EB updates all outputs at once.
// RL14 - Host waits over two device clocks after a command write.
// RL15 - Every stored setting reads back unchanged.
// RL16 - Low direction byte bits map nibbles in port order; 1 means output.
// RL17 - Polarity 0 reads high pin as 1, polarity 1 reads low pin as 1.
// RL18 - Polarity has no effect on output nibbles.
// RL19 - Reset makes all nibbles inputs with non-inverted polarity.
// RL20 - Output values drive only output nibbles; input nibbles stay undriven.
// RL21 - Selected port read view stays until another view command.
// RL22 - Polarity bits sit in the high byte, same nibble order.
// RL23 - Undefined command codes change nothing.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "gcd_params.svh"
module gcd_top
    import gcd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register bus
    input wire gcd_axi_req_t axi_req,
    output gcd_axi_rsp_t axi_rsp,
    // Port pins
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe_n,
    // Command status
    output logic cmd_busy
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function automatic logic [31:0] nib_mask(input logic [7:0] bits);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 8; i++) begin
        m[i*4 +: 4] = {4{bits[i]}};
    end
    return m;
endfunction

function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                     input logic en);
    return en ? nw : old;
endfunction

////////////////////////////////////////////////////////////////////////////////
// State

gcd_state_s_t s_reg;
gcd_state_s_t s_next;
logic [31:0] dir_mask;
logic [31:0] pol_mask;
logic [31:0] in_logic;
logic [31:0] view_data;

assign dir_mask = nib_mask(s_reg.setting[0][7:0]); // RL16
assign pol_mask = nib_mask(s_reg.setting[0][15:8]) & ~dir_mask; // RL22 RL18
assign in_logic = s_reg.in_s2 ^ pol_mask; // RL17

always_comb begin
    case (s_reg.view)
        8'he5: view_data = (in_logic & ~dir_mask) | (s_reg.out_live & dir_mask);
        8'he7: view_data = s_reg.latch;
        8'he8: view_data = s_reg.out_live;
        8'he9: view_data = s_reg.trans;
        default: view_data = in_logic;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Next state

always_comb begin
    logic [7:0] c;
    logic wr_fire;
    logic rd_fire;
    logic [31:0] rdat;
    logic [1:0] rresp;
    logic [31:0] wd;
    c = 8'h0;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    rdat = 32'h0;
    rresp = 2'b00;
    wd = 32'h0;
    s_next = s_reg;
    s_next.in_s1 = pin_in;
    s_next.in_s2 = s_reg.in_s1;
    s_next.in_prev = in_logic;
    // Transition trapping in both directions
    s_next.trans = s_reg.trans | (in_logic ^ s_reg.in_prev);

    // Write channel handshakes
    if (axi_req.awvalid && s_reg.rsp.awready) begin
        s_next.aw_got = 1'b1;
        s_next.aw_addr = axi_req.awaddr;
        s_next.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && s_reg.rsp.wready) begin
        s_next.w_got = 1'b1;
        s_next.w_data = axi_req.wdata;
        s_next.w_strb = axi_req.wstrb;
        s_next.rsp.wready = 1'b0;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.rsp.bvalid) begin
        wr_fire = 1'b1;
        s_next.rsp.bvalid = 1'b1;
        s_next.rsp.bresp = 2'b00;
        s_next.aw_got = 1'b0;
        s_next.w_got = 1'b0;
    end
    if (s_reg.rsp.bvalid && axi_req.bready) begin
        s_next.rsp.bvalid = 1'b0;
        s_next.rsp.awready = 1'b1;
        s_next.rsp.wready = 1'b1;
    end
    wd = s_reg.w_data;
    if (wr_fire && s_reg.w_strb[0]) begin
        case (s_reg.aw_addr)
            `GCD_ADDR_WDL: s_next.wdl = wd[7:0]; // RL1 RL2
            `GCD_ADDR_WDH: s_next.wdh = wd[7:0]; // RL1
            `GCD_ADDR_OUT: s_next.out_val = wd;
            `GCD_ADDR_CMD: begin
                c = wd[7:0];
                s_next.state = GCD_BUSY; // RL14
                s_next.busy_cnt = 2'(`GCD_BUSY_CYCLES);
            end
            default: s_next.rsp.bresp = 2'b10;
        endcase
    end else if (wr_fire) begin
        if (s_reg.aw_addr == `GCD_ADDR_OUT) begin
            for (int b = 1; b < 4; b++) begin
                s_next.out_val[b*8 +: 8] = merge(s_reg.out_val[b*8 +: 8], wd[b*8 +: 8],
                                                 s_reg.w_strb[b]);
            end
        end
    end
    if (wr_fire && s_reg.aw_addr == `GCD_ADDR_OUT && s_reg.w_strb[0]) begin
        for (int b = 1; b < 4; b++) begin
            s_next.out_val[b*8 +: 8] = merge(s_reg.out_val[b*8 +: 8], wd[b*8 +: 8],
                                             s_reg.w_strb[b]);
        end
    end

    // Command decode
    if (wr_fire && s_reg.aw_addr == `GCD_ADDR_CMD && s_reg.w_strb[0]) begin
        s_next.cmd = c;
        if (c >= `GCD_CMD_WR_FIRST && c <= `GCD_CMD_WR_LAST) begin
            s_next.setting[4'(c - `GCD_CMD_WR_FIRST)] = {s_reg.wdh, s_reg.wdl}; // RL6 RL15
        end else if (c >= `GCD_CMD_RD_FIRST && c <= `GCD_CMD_RD_LAST) begin
            {s_next.rdh, s_next.rdl} = s_reg.setting[4'(c - `GCD_CMD_RD_FIRST)]; // RL7 RL3
        end else if (c == `GCD_CMD_RD_VIEW) begin
            s_next.rdl = s_reg.view; // RL8
            s_next.rdh = 8'h00; // RL4
        end else if (c == `GCD_CMD_RD_TIMER) begin
            {s_next.rdh, s_next.rdl} = s_reg.tmr_cnt; // RL9 RL3
        end else if (c == `GCD_CMD_TMR_SINGLE) begin
            s_next.tmr = GCD_TMR_ONE; // RL10 RL5
            s_next.tmr_cnt = 16'h0;
        end else if (c == `GCD_CMD_TMR_CONT) begin
            s_next.tmr = GCD_TMR_RUN; // RL10
            s_next.tmr_cnt = 16'h0;
        end else if (c == `GCD_CMD_TMR_STOP) begin
            s_next.tmr = GCD_TMR_OFF; // RL10
        end else if (c == `GCD_CMD_TMR_CSTOP) begin
            if (s_reg.tmr != GCD_TMR_OFF) begin
                s_next.tmr = GCD_TMR_END; // RL10
            end
        end else if (c == `GCD_CMD_TRANS_CLR) begin
            s_next.trans = 32'h0; // RL11
        end else if (c >= `GCD_CMD_VIEW_FIRST && c <= `GCD_CMD_VIEW_LAST) begin
            s_next.view = c; // RL12 RL21
        end else if (c == `GCD_CMD_LATCH) begin
            s_next.latch = in_logic; // RL13
        end else if (c == `GCD_CMD_OUTSET) begin
            s_next.out_live = s_reg.out_val; // RL13
        end
        // Other codes fall through untouched RL23
    end

    // Timer counts device clocks up to the low 15 bits of setting 3
    case (s_reg.tmr)
        GCD_TMR_OFF: ;
        GCD_TMR_ONE, GCD_TMR_RUN, GCD_TMR_END: begin
            if (s_reg.tmr_cnt >= {1'b0, s_reg.setting[3][14:0]}) begin
                s_next.tmr_cnt = 16'h0;
                if (s_reg.tmr != GCD_TMR_RUN) begin
                    s_next.tmr = GCD_TMR_OFF;
                end
            end else begin
                s_next.tmr_cnt = s_reg.tmr_cnt + 16'h1;
            end
        end
        default: s_next.tmr = GCD_TMR_OFF;
    endcase

    // Busy window after a command
    case (s_reg.state)
        GCD_IDLE: ;
        GCD_BUSY: begin
            if (s_reg.busy_cnt <= 2'd1) begin
                s_next.state = GCD_IDLE;
            end
            s_next.busy_cnt = s_reg.busy_cnt - 2'd1;
        end
        default: s_next.state = GCD_IDLE;
    endcase

    // Read channel
    if (axi_req.arvalid && s_reg.rsp.arready) begin
        rd_fire = 1'b1;
        s_next.rsp.arready = 1'b0;
        s_next.rsp.rvalid = 1'b1;
        case (axi_req.araddr)
            `GCD_ADDR_RDL: rdat = {24'h0, s_reg.rdl};
            `GCD_ADDR_RDH: rdat = {24'h0, s_reg.rdh};
            `GCD_ADDR_OUT: rdat = s_reg.out_val;
            `GCD_ADDR_PORT: rdat = view_data;
            `GCD_ADDR_STAT: rdat = {30'h0, s_reg.tmr != GCD_TMR_OFF, s_reg.state == GCD_BUSY};
            `GCD_ADDR_CMD, `GCD_ADDR_WDL, `GCD_ADDR_WDH: rdat = 32'h0;
            default: rresp = 2'b10;
        endcase
        s_next.rsp.rdata = rdat;
        s_next.rsp.rresp = rresp;
    end
    if (s_reg.rsp.rvalid && axi_req.rready) begin
        s_next.rsp.rvalid = 1'b0;
        s_next.rsp.arready = 1'b1;
    end

    // Pins
    s_next.pin_out = s_reg.out_live & dir_mask; // RL20
    s_next.pin_oe_n = ~dir_mask; // RL20
    // Reading the transition view clears it; events of the same cycle stay
    if (rd_fire && axi_req.araddr == `GCD_ADDR_PORT && s_reg.view == 8'he9) begin
        s_next.trans = in_logic ^ s_reg.in_prev;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Registers

always_ff @(posedge mclk) begin
    if (rst) begin
        s_reg <= '0;
        s_reg.state <= GCD_IDLE;
        s_reg.tmr <= GCD_TMR_OFF;
        s_reg.setting[0] <= `GCD_RST_DIRPOL; // RL19
        s_reg.view <= `GCD_RST_VIEW;
        s_reg.rsp.awready <= 1'b1;
        s_reg.rsp.wready <= 1'b1;
        s_reg.rsp.arready <= 1'b1;
        s_reg.pin_oe_n <= 32'hffffffff; // RL19
    end else begin
        s_reg <= s_next;
    end
end

assign axi_rsp = s_reg.rsp;
assign pin_out = s_reg.pin_out;
assign pin_oe_n = s_reg.pin_oe_n;
assign cmd_busy = (s_reg.state == GCD_BUSY);

endmodule // gcd_top

// ===== sim/gcd_pin_model.sv
// Board side of the port pins: outside levels plus read-back of driven nibbles
// Assumes the bench sets ext_level and wires pin_in to the dispatcher
`timescale 1ns/10ps
module gcd_pin_model (
    // Pins
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n,
    input wire logic [31:0] ext_level,
    output logic [31:0] pin_in
);
    // Driven nibbles show the device level, the rest the outside level
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule // gcd_pin_model

// ===== sim/gcd_monitor.sv
// Checker of bus answers, busy window and pin states of the dispatcher
// Assumes binding to gcd_top by port names
`timescale 1ns/10ps
module gcd_monitor
    import gcd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register bus
    input wire gcd_axi_req_t axi_req,
    input wire gcd_axi_rsp_t axi_rsp,
    // Pins and status
    input wire logic [31:0] pin_in,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n,
    input wire logic cmd_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_reset_undriven: assert property ($fell(rst) |-> pin_oe_n == '1)
        else $error("pins driven after reset");
    a_busy_window: assert property ($rose(cmd_busy) |-> cmd_busy [*2] ##1 !cmd_busy)
        else $error("busy window wrong");
    a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready
        && axi_req.wvalid && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid)
        else $error("write not answered");
    a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready
        |-> ##[1:2] axi_rsp.rvalid)
        else $error("read not answered");
    a_read_held: assert property (axi_req.arvalid && axi_rsp.arready |=> !axi_rsp.arready)
        else $error("read taken twice");
    a_write_held: assert property (axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready)
        else $error("write taken twice");
    a_bresp_drop: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
        else $error("write answer repeated");
    a_rresp_drop: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
        else $error("read answer repeated");
    a_out_cause: assert property ($changed(pin_out)
        |-> axi_rsp.bvalid || $past(axi_rsp.bvalid))
        else $error("pin level changed without command");
    cover property ($rose(cmd_busy));
    cover property (axi_rsp.rvalid && axi_rsp.rresp == 2'b10);
    cover property ($fell(pin_oe_n[0]));
endmodule // gcd_monitor
////////////////////////////////////////
bind gcd_top gcd_monitor u_monitor(.mclk, .rst, .axi_req, .axi_rsp, .pin_in, .pin_out,
    .pin_oe_n, .cmd_busy);

// ===== sim/gcd_top_bench.sv
// Bench of the dispatcher: AXI4-Lite host tasks and command sequences
// Assumes gcd_top, gcd_pin_model and the params header on the include path
`timescale 1ns/10ps
`include "gcd_params.svh"
module gcd_top_bench import gcd_pkg::*; ();
    logic mclk;
    logic rst;
    logic busy;
    gcd_axi_req_t req;
    gcd_axi_rsp_t rsp;
    logic [31:0] pin_in, pin_out, pin_oe_n, ext, rv;
    logic [1:0] rr;
    logic [7:0] k;
    logic [15:0] tcnt;
    logic [7:0] tc [5] = '{8'he1, 8'he2, 8'he0, 8'he1, 8'he3};
    logic te [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    int err_total;
    int compares;
    gcd_top dut(.mclk(mclk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .cmd_busy(busy));
    gcd_pin_model pins(.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext),
        .pin_in(pin_in));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req.awaddr <= a;
        req.wdata <= d;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
        if (a == `GCD_ADDR_CMD) chk({31'h0, busy}, 32'h1, "cmd_busy");
        repeat (4) @(posedge mclk);
        if (a == `GCD_ADDR_CMD) chk({31'h0, busy}, 32'h0, "cmd_busy");
    endtask
    task automatic rd(input logic [7:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        rv = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
        wr(`GCD_ADDR_WDL, {24'h0, lo});
        wr(`GCD_ADDR_WDH, {24'h0, hi});
        wr(`GCD_ADDR_CMD, {24'h0, c});
    endtask
    task automatic rb(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
        wr(`GCD_ADDR_CMD, {24'h0, c});
        rd(`GCD_ADDR_RDL);
        chk(rv, {24'h0, lo}, "read_data_low");
        rd(`GCD_ADDR_RDH);
        chk(rv, {24'h0, hi}, "read_data_high");
    endtask
    task automatic complete_run();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #300us;
        err_total++;
        complete_run();
    end
    initial begin
        req = '0;
        req.wstrb = 4'hf;
        ext = 32'h5a5a5a5a;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        chk(pin_oe_n, 32'hffffffff, "pin_oe_n");
        rb(8'hd0, 8'h00, 8'h00);
        for (k = 0; k < 9; k++) cmd(8'hc0 + k, 8'h30 + k, 8'h60 + k);
        for (k = 0; k < 9; k++) rb(8'hd0 + k, 8'h30 + k, 8'h60 + k);
        for (k = 0; k < 5; k++) begin
            wr(`GCD_ADDR_CMD, {24'h0, 8'he5 + k});
            rb(8'hd9, 8'he5 + k, 8'h00);
        end
        wr(`GCD_ADDR_CMD, 32'h000000bf);
        rd(`GCD_ADDR_RDL);
        chk(rv, 32'h000000e9, "read_data_low");
        rd(8'h20);
        chk({30'h0, rr}, 32'h2, "rresp");
        cmd(8'hc1, 8'h00, 8'h00);
        cmd(8'hc0, 8'h01, 8'h00);
        chk(pin_oe_n, 32'hfffffff0, "pin_oe_n");
        wr(`GCD_ADDR_OUT, 32'hffffffff);
        chk(pin_out & ~pin_oe_n, 32'h0, "pin_out");
        wr(`GCD_ADDR_CMD, 32'h000000eb);
        chk(pin_out & ~pin_oe_n, 32'h0000000f, "pin_out");
        cmd(8'hc0, 8'h01, 8'h03);
        wr(`GCD_ADDR_CMD, 32'h000000e5);
        rd(`GCD_ADDR_PORT);
        chk(rv, 32'h5a5a5aaf, "port_view");
        wr(`GCD_ADDR_CMD, 32'h000000e4);
        wr(`GCD_ADDR_CMD, 32'h000000e9);
        rd(`GCD_ADDR_PORT);
        chk(rv, 32'h0, "transitions");
        ext <= 32'h5a5a5aa5;
        repeat (6) @(posedge mclk);
        rd(`GCD_ADDR_PORT);
        chk(rv, 32'h000000f0, "transitions");
        wr(`GCD_ADDR_CMD, 32'h000000e6);
        rd(`GCD_ADDR_PORT);
        chk(rv, 32'h5a5a5a5f, "live_view");
        wr(`GCD_ADDR_CMD, 32'h000000ea);
        ext <= 32'h00000000;
        wr(`GCD_ADDR_CMD, 32'h000000e7);
        rd(`GCD_ADDR_PORT);
        chk(rv, 32'h5a5a5a5f, "latched_view");
        wr(`GCD_ADDR_CMD, 32'h000000e8);
        rd(`GCD_ADDR_PORT);
        chk(rv, 32'hffffffff, "output_view");
        cmd(8'hc3, 8'h40, 8'h00);
        for (k = 0; k < 5; k++) begin
            wr(`GCD_ADDR_CMD, {24'h0, tc[k]});
            rd(`GCD_ADDR_STAT);
            chk({31'h0, rv[1]}, {31'h0, te[k]}, "timer_run");
        end
        repeat (100) @(posedge mclk);
        rd(`GCD_ADDR_STAT);
        chk({31'h0, rv[1]}, 32'h0, "timer_run");
        wr(`GCD_ADDR_CMD, 32'h000000e0);
        wr(`GCD_ADDR_CMD, 32'h000000da);
        rd(`GCD_ADDR_RDL);
        tcnt[7:0] = rv[7:0];
        rd(`GCD_ADDR_RDH);
        tcnt[15:8] = rv[7:0];
        chk({31'h0, tcnt != 16'h0 && tcnt <= 16'h40}, 32'h1, "timer_count");
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        chk(pin_oe_n, 32'hffffffff, "pin_oe_n");
        rb(8'hd0, 8'h00, 8'h00);
        rb(8'hd9, 8'he6, 8'h00);
        complete_run();
    end
endmodule // gcd_top_bench
